// ---- hdl/bai_link_if.sv ----
// Cable link between the host adapter end and the remote backplane end.
`timescale 1ns/100ps
interface bai_link_if;
    // ==========================================================
    // Remote to host.
    logic [7:1] bp_line; // Backplane levels on cable lines.
    logic pt_rx_tgl; // Toggle: transmitter interrupt sent to host.
    logic pr_rx_tgl; // Toggle: receiver interrupt sent to host.
    logic pt_tx_ack_tgl; // Toggle: outgoing transmitter interrupt acknowledged.
    logic done_tgl; // Toggle: remote transfer finished.
    logic done_berr; // Finished transfer ended in bus error.
    logic [7:0] done_data; // Returned data.
    logic done_par; // Odd parity over returned data.
    // ==========================================================
    // Host to remote.
    logic [7:1] cable_irq_line; // Outgoing transmitter interrupt line.
    logic pr_tx_tgl; // Toggle: receiver interrupt to remote.
    logic pt_ack_tgl; // Toggle: host acknowledges received transmitter irq.
    logic iack_tgl; // Toggle: acknowledge cycle request.
    logic [2:0] iack_lvl; // Level to acknowledge.
    logic xfer_tgl; // Toggle: start remote transfer.
    modport pci (input bp_line, pt_rx_tgl, pr_rx_tgl, pt_tx_ack_tgl, done_tgl, done_berr,
        done_data, done_par, output cable_irq_line, pr_tx_tgl, pt_ack_tgl, iack_tgl, iack_lvl,
        xfer_tgl);
    modport vme (output bp_line, pt_rx_tgl, pr_rx_tgl, pt_tx_ack_tgl, done_tgl, done_berr,
        done_data, done_par, input cable_irq_line, pr_tx_tgl, pt_ack_tgl, iack_tgl, iack_lvl,
        xfer_tgl);
endinterface

// ---- hdl/bai_pci_end.sv ----
// Host adapter end: interrupt merge, status and command registers.
`timescale 1ns/100ps
module bai_pci_end import bai_pkg::*; #(
    parameter int TMO_CYC_P = TMO_CYC // Timeout length in clocks.
) (
    input wire logic clk, // System clock, 20 MHz.
    input wire logic rst_n, // Synchronous reset, active low.
    input wire logic [7:0] addr, // Register index.
    input wire logic [7:0] wdata, // Write data.
    input wire logic wr, // Write strobe.
    input wire logic rd, // Read strobe.
    output logic [7:0] rdata_q, // Read data, valid the cycle after rd.
    input wire logic xfer_req, // Pulse: start a transfer to the remote bus.
    output logic xfer_busy_q, // Transfer outstanding.
    input wire logic dma_done, // Pulse: DMA operation finished.
    input wire logic [7:1] bp_pass_jmp, // Backplane pass jumpers, high when installed.
    output logic inta_n_q, // Interrupt request, active low.
    bai_link_if.pci lk // Cable link.
);
    localparam int SW = 28; // Width of the synchronised bundle.
    localparam logic [15:0] CNT_LAST = 16'(TMO_CYC_P - 1); // Count at which the wait ends.
    logic [SW-1:0] s_q; // Synchronised link and jumper inputs.
    logic [7:1] bp_s, jmp_s; // Synchronised backplane levels and jumpers.
    logic pt_rx_s, pr_rx_s, done_s, berr_s, par_s, ptack_s; // Synchronised link bits.
    logic [7:0] data_s; // Synchronised returned data.
    logic [3:0] tg_q; // Previous values of the four toggles.
    logic pt_rx_ev, pr_rx_ev, done_ev, ptack_ev; // One-cycle event strobes.
    logic [7:0] ctrl_q; // Interrupt control, bits 7, 4 and 3 unused in storage.
    logic pt_out_q, pr_pend_q, pt_rx_q; // Programmed interrupt flags.
    logic berr_q, tmo_q, derr_q; // Latched error status.
    logic dma_en_q, dma_done_q; // DMA done enable and flag.
    logic [2:0] iack_lvl_q; // Acknowledge level field.
    logic pr_tx_q, pt_ack_q, iack_q, xfer_q; // Outgoing toggles.
    logic [7:1] line_q; // Outgoing cable line drive.
    bai_xfer_t xst_q; // Transfer tracker state.
    logic [15:0] cnt_q; // Timeout counter.
    logic [7:1] bp_pass; // Backplane levels after jumpers.
    logic irq_any; // Some enabled source is pending.
    logic w_lcmd, w_rcmd; // Command register write strobes.

    if (TMO_CYC_P < 2 || TMO_CYC_P > 65535)
    begin
        $error("bai_pci_end: bad timeout length.");
    end

    // ==========================================================
    // Input crossing: every link bit and jumper passes two flops.
    bai_sync #(.W(SW)) u_sync (
        .clk(clk),
        .rst_n(rst_n),
        .d({bp_pass_jmp, lk.bp_line, lk.pt_rx_tgl, lk.pr_rx_tgl, lk.done_tgl, lk.done_berr,
            lk.done_par, lk.done_data, lk.pt_tx_ack_tgl}),
        .q(s_q)
    );
    assign {jmp_s, bp_s, pt_rx_s, pr_rx_s, done_s, berr_s, par_s, data_s, ptack_s} = s_q;

    // Toggle edges become single-cycle events.
    always_ff @(posedge clk)
    begin
        if (!rst_n) tg_q <= '0;
        else tg_q <= {pt_rx_s, pr_rx_s, done_s, ptack_s};
    end
    assign pt_rx_ev = pt_rx_s ^ tg_q[3];
    assign pr_rx_ev = pr_rx_s ^ tg_q[2];
    assign done_ev = done_s ^ tg_q[1];
    assign ptack_ev = ptack_s ^ tg_q[0];

    assign w_lcmd = wr && addr == A_LCMD;
    assign w_rcmd = wr && addr == A_RCMD1;
    assign bp_pass = bp_s & jmp_s;

    // ==========================================================
    // Interrupt control: enables and outgoing line select.
    always_ff @(posedge clk)
    begin
        if (!rst_n) ctrl_q <= INT_CTRL_RST;
        else if (wr && addr == A_INT_CTRL) ctrl_q <= wdata & 8'h67;
    end

    // ==========================================================
    // Outgoing transmitter interrupt: held on the chosen line until the remote acks.
    // Code zero sends nothing, so a send request with no line is dropped.
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            pt_out_q <= 1'b0;
            line_q <= '0;
        end
        else
        begin
            if (w_lcmd && wdata[B_LC_SEND_PT] && ctrl_q[2:0] != SEL_NONE)
                pt_out_q <= 1'b1;
            else if (ptack_ev)
                pt_out_q <= 1'b0;
            line_q <= pt_out_q ? 7'((8'h01 << ctrl_q[2:0]) >> 1) : '0;
        end
    end
    assign lk.cable_irq_line = line_q;

    // ==========================================================
    // Incoming programmed interrupts; a new arrival wins over a clear.
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            pr_pend_q <= 1'b0;
            pt_rx_q <= 1'b0;
        end
        else
        begin
            if (pr_rx_ev) pr_pend_q <= 1'b1;
            else if (w_lcmd && wdata[B_LC_CLR_PR]) pr_pend_q <= 1'b0;
            if (pt_rx_ev) pt_rx_q <= 1'b1;
            else if (w_rcmd && wdata[B_RC_ACK_PT]) pt_rx_q <= 1'b0;
        end
    end

    // ==========================================================
    // Remote command register 1: send, acknowledge and iack level.
    // The acknowledge read is one toggle per read; the host must not repeat it.
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            pr_tx_q <= 1'b0;
            pt_ack_q <= 1'b0;
            iack_q <= 1'b0;
            iack_lvl_q <= '0;
        end
        else
        begin
            if (w_rcmd)
            begin
                iack_lvl_q <= wdata[2:0];
                if (wdata[B_RC_SEND_PR]) pr_tx_q <= ~pr_tx_q;
                if (wdata[B_RC_ACK_PT]) pt_ack_q <= ~pt_ack_q;
            end
            if (rd && addr == A_IACK_LO) iack_q <= ~iack_q;
        end
    end
    assign lk.pr_tx_tgl = pr_tx_q;
    assign lk.pt_ack_tgl = pt_ack_q;
    assign lk.iack_tgl = iack_q;
    assign lk.iack_lvl = iack_lvl_q;

    // ==========================================================
    // Remote transfer tracker with timeout; a late answer after timeout is dropped.
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            xst_q <= XF_IDLE;
            cnt_q <= '0;
            xfer_q <= 1'b0;
        end
        else
        begin
            case (xst_q)
                XF_IDLE:
                begin
                    cnt_q <= '0;
                    if (xfer_req)
                    begin
                        xfer_q <= ~xfer_q;
                        xst_q <= XF_WAIT;
                    end
                end
                XF_WAIT:
                begin
                    cnt_q <= cnt_q + 16'h0001;
                    if (done_ev || cnt_q == 16'(TMO_CYC_P - 1)) xst_q <= XF_IDLE;
                end
                default: xst_q <= XF_IDLE;
            endcase
        end
    end
    assign lk.xfer_tgl = xfer_q;
    always_ff @(posedge clk)
    begin
        if (!rst_n) xfer_busy_q <= 1'b0;
        else xfer_busy_q <= (xst_q == XF_IDLE) ? xfer_req : !done_ev && cnt_q != CNT_LAST;
    end

    // ==========================================================
    // Latched errors; an error arriving with the clear still latches.
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            berr_q <= 1'b0;
            tmo_q <= 1'b0;
            derr_q <= 1'b0;
        end
        else
        begin
            if (w_lcmd && wdata[B_LC_CLR_ERR])
            begin
                berr_q <= 1'b0;
                tmo_q <= 1'b0;
                derr_q <= 1'b0;
            end
            if (xst_q == XF_WAIT && done_ev && berr_s) berr_q <= 1'b1;
            if (xst_q == XF_WAIT && !done_ev && cnt_q == 16'(TMO_CYC_P - 1)) tmo_q <= 1'b1;
            if (xst_q == XF_WAIT && done_ev && !(^{data_s, par_s})) derr_q <= 1'b1;
        end
    end

    // ==========================================================
    // DMA done: software can only clear the flag; the engine's pulse wins.
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            dma_en_q <= 1'b0;
            dma_done_q <= 1'b0;
        end
        else
        begin
            if (wr && addr == A_DMA_CMD) dma_en_q <= wdata[B_DMA_EN];
            if (dma_done) dma_done_q <= 1'b1;
            else if (wr && addr == A_DMA_CMD && !wdata[B_DMA_DONE]) dma_done_q <= 1'b0;
        end
    end

    // ==========================================================
    // Request merge: a level, held while any enabled source is pending.
    assign irq_any = (ctrl_q[B_IC_NORM_EN] && (pr_pend_q || pt_rx_q || |bp_pass
        || (dma_en_q && dma_done_q)))
        || (ctrl_q[B_IC_ERR_EN] && (berr_q || tmo_q || derr_q));
    always_ff @(posedge clk)
    begin
        if (!rst_n) inta_n_q <= 1'b1;
        else inta_n_q <= !irq_any;
    end

    // ==========================================================
    // Read port; unmapped indices read zero.
    always_ff @(posedge clk)
    begin
        if (!rst_n) rdata_q <= '0;
        else if (!rd) rdata_q <= '0;
        else
        begin
            case (addr)
                A_INT_CTRL: rdata_q <= {!inta_n_q, ctrl_q[6:0]};
                A_INT_STAT: rdata_q <= {bp_pass | line_q, 1'b0};
                A_LSTAT: rdata_q <= {2'b00, pr_pend_q, 2'b00, derr_q, tmo_q, berr_q};
                A_RSTAT: rdata_q <= {6'h00, pt_rx_q, 1'b0};
                A_RCMD1: rdata_q <= {5'h00, iack_lvl_q};
                A_DMA_CMD: rdata_q <= {5'h00, dma_en_q, dma_done_q, 1'b0};
                default: rdata_q <= '0;
            endcase
        end
    end
endmodule

// ---- hdl/bai_pkg.sv ----
// Shared constants, register map and types for the adapter interrupt control.
package bai_pkg;
    // ==========================================================
    // Timing.
    localparam int CLK_NS = 50; // Clock period in ns at 20 MHz.
    localparam int TMO_US = 30; // Remote transfer timeout in microseconds.
    localparam int TMO_CYC = (TMO_US * 1000) / CLK_NS; // Longest wait, rounded down.
    // ==========================================================
    // Register indices on the host port.
    localparam logic [7:0] A_INT_CTRL = 8'h00; // Local interrupt control.
    localparam logic [7:0] A_INT_STAT = 8'h01; // Local interrupt status (levels).
    localparam logic [7:0] A_LCMD = 8'h02; // Local command (write-one actions).
    localparam logic [7:0] A_LSTAT = 8'h03; // Local status.
    localparam logic [7:0] A_RSTAT = 8'h04; // Remote status.
    localparam logic [7:0] A_RCMD1 = 8'h05; // Remote command register 1.
    localparam logic [7:0] A_IACK_LO = 8'h06; // Acknowledge-read low.
    localparam logic [7:0] A_DMA_CMD = 8'h07; // Local DMA command.
    // ==========================================================
    // Field positions.
    localparam int B_IC_ACTIVE = 7; // Device is requesting.
    localparam int B_IC_NORM_EN = 6; // Normal interrupt enable.
    localparam int B_IC_ERR_EN = 5; // Error interrupt enable.
    localparam int B_LC_CLR_ERR = 7; // Acknowledge error interrupt.
    localparam int B_LC_CLR_PR = 6; // Clear received receiver interrupt.
    localparam int B_LC_SEND_PT = 5; // Send transmitter interrupt.
    localparam int B_LS_PR = 5; // Receiver interrupt pending.
    localparam int B_LS_DERR = 2; // Interface data error.
    localparam int B_LS_TMO = 1; // Interface timeout.
    localparam int B_LS_BERR = 0; // Remote bus error.
    localparam int B_RS_PT = 1; // Transmitter interrupt received.
    localparam int B_RC_ACK_PT = 6; // Acknowledge received transmitter irq.
    localparam int B_RC_SEND_PR = 5; // Send receiver interrupt.
    localparam int B_DMA_EN = 2; // DMA done interrupt enable.
    localparam int B_DMA_DONE = 1; // DMA done flag.
    // ==========================================================
    // Reset values.
    localparam logic [7:0] INT_CTRL_RST = 8'h00; // All sources gated off.
    localparam logic [2:0] SEL_NONE = 3'h0; // Line code that sends nothing.
    // ==========================================================
    // Remote transfer tracker states.
    typedef enum logic {XF_IDLE = 1'b0, XF_WAIT = 1'b1} bai_xfer_t;
endpackage

// ---- hdl/bai_sync.sv ----
// Two-stage synchroniser for a bundle of level signals.
`timescale 1ns/100ps
module bai_sync #(
    parameter int W = 1 // Bundle width.
) (
    input wire logic clk, // System clock.
    input wire logic rst_n, // Synchronous reset, active low.
    input wire logic [W-1:0] d, // Asynchronous inputs.
    output logic [W-1:0] q // Synchronised outputs.
);
    logic [W-1:0] meta_q; // First stage, read only by the second.

    if (W < 1)
    begin
        $error("bai_sync: width must be positive.");
    end

    // ==========================================================
    // Two flops; the first may go metastable, so only the second reads it.
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            meta_q <= '0;
            q <= '0;
        end
        else
        begin
            meta_q <= d;
            q <= meta_q;
        end
    end
endmodule

// ---- hdl/bai_vme_end.sv ----
// Remote backplane end: drives cable lines and answers host commands.
`timescale 1ns/100ps
module bai_vme_end import bai_pkg::*; (
    input wire logic clk, // System clock.
    input wire logic rst_n, // Synchronous reset, active low.
    input wire logic [7:1] bp_irq, // Backplane interrupt levels, high when active.
    input wire logic pt_send, // Pulse: send transmitter interrupt to host.
    input wire logic pr_send, // Pulse: send receiver interrupt to host.
    input wire logic pt_ack, // Pulse: acknowledge host transmitter interrupt.
    input wire logic pr_ack, // Pulse: acknowledge host receiver interrupt.
    input wire logic xfer_done, // Pulse: remote transfer finished.
    input wire logic xfer_berr, // With xfer_done: ended in bus error.
    input wire logic [7:0] xfer_data, // With xfer_done: returned data.
    output logic [7:1] pt_irq_q, // Host transmitter interrupt on cable lines.
    output logic pr_irq_q, // Host receiver interrupt pending.
    output logic pt_acked_q, // Host acknowledged our transmitter irq (pulse).
    output logic iack_q, // Pulse: run acknowledge cycle.
    output logic [2:0] iack_lvl_q, // Level for the acknowledge cycle.
    output logic xfer_q, // Pulse: start a transfer.
    bai_link_if.vme lk // Cable link.
);
    localparam int SW = 21; // Width of the synchronised bundle.
    logic [SW-1:0] s_q; // Synchronised inputs.
    logic [7:1] bp_s, line_s; // Synchronised levels.
    logic prtx_s, ptack_s, iack_s, xfer_s; // Synchronised toggles.
    logic [2:0] lvl_s; // Synchronised level field.
    logic [3:0] tg_q; // Previous toggle values.
    logic pt_tg_q, pr_tg_q, ack_tg_q, done_tg_q, berr_q, par_q; // Outgoing link flops.
    logic [7:0] data_q; // Outgoing data.
    logic [7:1] bp_q; // Outgoing backplane levels.

    // ==========================================================
    // Link and backplane inputs pass two flops.
    bai_sync #(.W(SW)) u_sync (
        .clk(clk),
        .rst_n(rst_n),
        .d({bp_irq, lk.cable_irq_line, lk.pr_tx_tgl, lk.pt_ack_tgl, lk.iack_tgl, lk.xfer_tgl,
            lk.iack_lvl}),
        .q(s_q)
    );
    assign {bp_s, line_s, prtx_s, ptack_s, iack_s, xfer_s, lvl_s} = s_q;

    // ==========================================================
    // Host toggles leave as pulses, except the receiver interrupt, held as a flag; the transmitter lines and iack level pass through as levels.
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            tg_q <= '0;
            pr_irq_q <= 1'b0;
            pt_acked_q <= 1'b0;
            iack_q <= 1'b0;
            iack_lvl_q <= '0;
            xfer_q <= 1'b0;
            pt_irq_q <= '0;
        end
        else
        begin
            tg_q <= {prtx_s, ptack_s, iack_s, xfer_s};
            // A new receiver interrupt wins over a local acknowledge.
            if (prtx_s ^ tg_q[3]) pr_irq_q <= 1'b1;
            else if (pr_ack) pr_irq_q <= 1'b0;
            pt_acked_q <= ptack_s ^ tg_q[2];
            iack_q <= iack_s ^ tg_q[1];
            iack_lvl_q <= lvl_s;
            xfer_q <= xfer_s ^ tg_q[0];
            pt_irq_q <= line_s;
        end
    end

    // ==========================================================
    // Outgoing events and transfer results; data and parity settle with the toggle.
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            pt_tg_q <= 1'b0;
            pr_tg_q <= 1'b0;
            ack_tg_q <= 1'b0;
            done_tg_q <= 1'b0;
            berr_q <= 1'b0;
            data_q <= '0;
            par_q <= 1'b1;
            bp_q <= '0;
        end
        else
        begin
            if (pt_send) pt_tg_q <= ~pt_tg_q;
            if (pr_send) pr_tg_q <= ~pr_tg_q;
            if (pt_ack) ack_tg_q <= ~ack_tg_q;
            if (xfer_done)
            begin
                done_tg_q <= ~done_tg_q;
                berr_q <= xfer_berr;
                data_q <= xfer_data;
                par_q <= ~(^xfer_data);
            end
            bp_q <= bp_s;
        end
    end
    assign lk.bp_line = bp_q;
    assign lk.pt_rx_tgl = pt_tg_q;
    assign lk.pr_rx_tgl = pr_tg_q;
    assign lk.pt_tx_ack_tgl = ack_tg_q;
    assign lk.done_tgl = done_tg_q;
    assign lk.done_berr = berr_q;
    assign lk.done_data = data_q;
    assign lk.done_par = par_q;
endmodule

// ---- test/bai_link_assertions.sv ----
// Concurrent checks on the cable link between the two adapter ends.
`timescale 1ns/100ps
module bai_link_assertions (
    input wire logic clk, // System clock.
    input wire logic rst_n, // Synchronous reset, active low.
    input wire logic [7:1] cable_irq_line, // Outgoing transmitter line.
    input wire logic pt_tx_ack_tgl, // Remote acknowledge toggle.
    input wire logic xfer_tgl, // Transfer start toggle.
    input wire logic done_tgl, // Transfer finished toggle.
    input wire logic done_berr, // Bus error with finish.
    input wire logic [7:0] done_data, // Returned data.
    input wire logic done_par // Odd parity over returned data.
);
    // ==========================================================
    // Helper logic.
    logic ack_prev_q; // Last seen acknowledge toggle.
    logic [3:0] ack_age_q; // Cycles since the acknowledge toggle moved, saturating.
    // Age counter: a line may only drop shortly after an acknowledge arrives.
    always_ff @(posedge clk)
    begin
        ack_prev_q <= pt_tx_ack_tgl;
        if (!rst_n || ack_prev_q != pt_tx_ack_tgl)
            ack_age_q <= 4'h0;
        else if (ack_age_q != 4'hf)
            ack_age_q <= ack_age_q + 4'h1;
    end
    // ==========================================================
    // Assertions.
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    AST_LINE_ONEHOT: assert property ($onehot0(cable_irq_line))
        else $error("More than one outgoing cable line active");
    AST_LINE_HOLD: assert property ((|cable_irq_line && |$past(cable_irq_line)) |->
        $stable(cable_irq_line))
        else $error("Outgoing cable line changed while held");
    AST_LINE_DROP: assert property ($fell(|cable_irq_line) |-> ack_age_q <= 4'h6)
        else $error("Outgoing cable line dropped without acknowledge");
    AST_LINE_RISE: assert property ($rose(|cable_irq_line) |=> (|cable_irq_line) [*4])
        else $error("Outgoing cable line too short");
    AST_PARITY: assert property (^{done_data, done_par})
        else $error("Returned data parity is not odd");
    AST_XFER_GAP: assert property ($changed(xfer_tgl) |=> $stable(xfer_tgl) [*4])
        else $error("Transfer started while one is outstanding");
    AST_DATA_HOLD: assert property ($stable(done_tgl) |-> $stable(done_data))
        else $error("Returned data moved without a finish event");
    AST_BERR_HOLD: assert property ($stable(done_tgl) |-> $stable(done_berr))
        else $error("Bus error flag moved without a finish event");
endmodule

// ---- test/testbench.sv ----
// Self-checking bench joining host and remote ends across the cable link.
`timescale 1ns/100ps
module testbench;
    import bai_pkg::*;
    // ==========================================================
    // Stimulus and observed signals.
    logic clk = 0, rst_n = 0, wr = 0, rd = 0, rd_p = 0, xfer_berr = 0;
    logic [6:0] pl = 7'h00; // Pulses: pt/pr send, pt/pr ack, done, xfer, dma.
    logic [7:0] addr = 8'h00, wdata = 8'h00, xfer_data = 8'h00, lfsr = 8'h15, exp_v;
    logic [7:1] jmp = 7'h00, bp_irq = 7'h00, pt_irq_q;
    logic [7:0] rdata_q;
    logic inta_n_q, pr_irq_q, xfer_busy_q, iack_q, xfer_q, pt_acked_q;
    logic [2:0] iack_lvl_q;
    logic [7:0] exp_q[$]; // Expected read data, oldest first.
    int miscompares = 0, num_checks = 0;
    int n_iack = 0, n_xfer = 0, n_ack = 0; // Remote pulses counted by the watcher.
    initial forever #25 clk = ~clk;
    bai_link_if bai_link_if_inst();
    // A short timeout keeps the run brief; expectations use the same value.
    bai_pci_end #(.TMO_CYC_P(20)) bai_pci_end_inst (.clk(clk), .rst_n(rst_n), .addr(addr),
        .wdata(wdata), .wr(wr), .rd(rd), .rdata_q(rdata_q), .xfer_req(pl[5]),
        .xfer_busy_q(xfer_busy_q), .dma_done(pl[6]), .bp_pass_jmp(jmp), .inta_n_q(inta_n_q),
        .lk(bai_link_if_inst));
    bai_vme_end bai_vme_end_inst (.clk(clk), .rst_n(rst_n), .bp_irq(bp_irq), .pt_send(pl[0]),
        .pr_send(pl[1]), .pt_ack(pl[2]), .pr_ack(pl[3]), .xfer_done(pl[4]),
        .xfer_berr(xfer_berr), .xfer_data(xfer_data), .pt_irq_q(pt_irq_q), .pr_irq_q(pr_irq_q),
        .pt_acked_q(pt_acked_q), .iack_q(iack_q), .iack_lvl_q(iack_lvl_q), .xfer_q(xfer_q),
        .lk(bai_link_if_inst));
    bai_link_assertions bai_link_assertions_inst (.clk(clk), .rst_n(rst_n),
        .cable_irq_line(bai_link_if_inst.cable_irq_line),
        .pt_tx_ack_tgl(bai_link_if_inst.pt_tx_ack_tgl), .xfer_tgl(bai_link_if_inst.xfer_tgl),
        .done_tgl(bai_link_if_inst.done_tgl), .done_berr(bai_link_if_inst.done_berr),
        .done_data(bai_link_if_inst.done_data), .done_par(bai_link_if_inst.done_par));
    // ==========================================================
    // Helpers.
    function automatic logic [7:0] nxt(logic [7:0] v);
        return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
    endfunction
    task automatic chk(logic [7:0] got, logic [7:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            miscompares++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Waits end 1 ns past the edge so that registered outputs have settled.
    task automatic wt(int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // The idle cycle after each strobe keeps one assignment per time step.
    task automatic wrr(logic [7:0] a, logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rdr(logic [7:0] a, logic [7:0] e);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        exp_q.push_back(e);
        @(posedge clk);
        rd <= 1'b0;
    endtask
    task automatic pls(int i);
        @(posedge clk);
        pl[i] <= 1'b1;
        @(posedge clk);
        pl[i] <= 1'b0;
    endtask
    task automatic irq(logic e);
        wt(1);
        chk({7'h0, inta_n_q}, {7'h0, e});
    endtask
    task automatic end_sim();
        $display("Checks %0d, mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    // Read data stand only in the cycle after the strobe; compare there.
    always @(posedge clk)
    begin
        if (rd_p)
            chk(rdata_q, exp_q.pop_front());
        rd_p <= rd;
        // Remote pulses stand one cycle, so each is counted once here.
        n_iack += int'(iack_q);
        n_xfer += int'(xfer_q);
        n_ack += int'(pt_acked_q);
    end
    // Watchdog well beyond the length of the whole sequence.
    initial
    begin
        repeat (5000) @(posedge clk);
        miscompares++;
        end_sim();
    end
    // ==========================================================
    // Main sequence.
    initial
    begin
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        rdr(A_INT_CTRL, 8'h00);
        rdr(8'h10, 8'h00);
        irq(1'b1);
        for (int c = 0; c < 8; c++)
        begin
            wrr(A_INT_CTRL, 8'(c));
            wrr(A_LCMD, 8'h20);
            wt(6);
            exp_v = 8'(1 << c) & 8'hfe;
            chk({pt_irq_q, 1'b0}, exp_v);
            rdr(A_INT_STAT, exp_v);
            irq(1'b1);
            pls(2);
            wt(8);
            rdr(A_INT_STAT, 8'h00);
        end
        lfsr = nxt(lfsr);
        wrr(A_INT_CTRL, 8'h40);
        @(posedge clk);
        // Level 7 always passes, so the acknowledge read below has a pending level.
        jmp <= lfsr[6:0] | 7'h40;
        bp_irq <= 7'h7f;
        wt(6);
        rdr(A_INT_STAT, {lfsr[6:0] | 7'h40, 1'b0});
        irq(1'b0);
        rdr(A_INT_CTRL, 8'hc0);
        wrr(A_RCMD1, 8'h07);
        rdr(A_IACK_LO, 8'h00);
        wrr(A_INT_CTRL, 8'h00);
        wt(2);
        irq(1'b1);
        @(posedge clk);
        bp_irq <= 7'h00;
        wrr(A_INT_CTRL, 8'h40);
        for (int k = 0; k < 2; k++)
        begin
            pls(k);
            wt(6);
            rdr(k ? A_LSTAT : A_RSTAT, k ? 8'h20 : 8'h02);
            irq(1'b0);
            wrr(k ? A_LCMD : A_RCMD1, 8'h40);
            wt(2);
            irq(1'b1);
        end
        wrr(A_RCMD1, 8'h25);
        wt(7);
        chk({7'h0, pr_irq_q}, 8'h01);
        chk({5'h0, iack_lvl_q}, 8'h05);
        pls(3);
        wt(2);
        chk({7'h0, pr_irq_q}, 8'h00);
        wrr(A_DMA_CMD, 8'h04);
        pls(6);
        wt(2);
        rdr(A_DMA_CMD, 8'h06);
        irq(1'b0);
        wrr(A_INT_CTRL, 8'h00);
        wt(2);
        irq(1'b1);
        wrr(A_DMA_CMD, 8'h04);
        wrr(A_INT_CTRL, 8'h60);
        wt(2);
        irq(1'b1);
        for (int k = 0; k < 3; k++)
        begin
            lfsr = nxt(lfsr);
            pls(5);
            wt(6);
            chk({7'h0, xfer_busy_q}, 8'h01);
            @(posedge clk);
            xfer_berr <= (k == 0);
            xfer_data <= lfsr;
            if (k != 1)
                pls(4);
            wt(30);
            rdr(A_LSTAT, k == 0 ? 8'h01 : k == 1 ? 8'h02 : 8'h00);
            rdr(A_INT_CTRL, k == 2 ? 8'h60 : 8'he0);
            irq(k == 2);
            wrr(A_LCMD, 8'h80);
            wt(2);
            irq(1'b1);
        end
        wt(4);
        chk(8'(n_iack), 8'h01);
        chk(8'(n_xfer), 8'h03);
        chk(8'(n_ack), 8'h01);
        end_sim();
    end
endmodule
